// ---- rtl/ecsf_top.v ----
`timescale 1ns/1ns
`include "ecsf_map.vh"
module ecsf_top #(
    parameter TICK_CYCLES = `ECSF_TICK_MS * 1000 * `ECSF_CLK_MHZ
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // drive state
    input wire net_mode,
    input wire cmd_src_ether,
    // received frame
    input wire rx_valid,
    input wire [31:0] rx_src_ip,
    input wire rx_is_cmd,
    // frame verdict
    output wire rx_done,
    output wire rx_pass,
    output wire cmd_pass,
    // supervision and settings
    output wire link_comm_fault,
    output wire output_shutoff,
    output wire bac_ip_en,
    output wire link_autoneg,
    output wire link_100m,
    output wire link_full_duplex
);
    // stored settings
    reg [15:0] app_select_1_ff, app_select_2_ff;
    reg [15:0] app_select_3_ff, app_select_4_ff;
    reg [13:0] loss_check_interval_ff;
    reg [31:0] cmd_src_addr_ff, filter_addr_ff;
    reg [13:0] cmd_src_octet3_limit_ff, cmd_src_octet4_limit_ff;
    reg [13:0] filter_octet2_limit_ff, filter_octet3_limit_ff;
    reg [13:0] filter_octet4_limit_ff;
    reg [2:0] link_speed_duplex_sel_ff;
    reg [9:0] dev_id_upper_ff;
    reg [13:0] dev_id_lower_ff;
    // active copies, loaded only at reset or apply
    reg [31:0] act_caddr_ff, act_faddr_ff;
    reg [13:0] act_c3lim_ff, act_c4lim_ff;
    reg [13:0] act_f2lim_ff, act_f3lim_ff, act_f4lim_ff;
    reg bac_en_ff, autoneg_ff, speed100_ff, full_ff;
    // supervision state
    reg fault_ff, sup_ff;
    reg [31:0] tick_ff;
    reg [13:0] loss_cnt_ff;
    // verdict
    reg done_ff, pass_ff, cmd_ff;
    wire acc, resp, wr_fire, apply;
    reg hit, wr_ok;
    reg [31:0] rdata;

    assign acc = psel & penable;
    assign resp = acc & ~pready;
    assign wr_fire = acc & pready & pwrite & ~pslverr;
    assign apply = wr_fire & (paddr == `ECSF_OFF_CTRL) &
                   pwdata[`ECSF_CTRL_APPLY];

    // address decode, write check and read mux
    always @* begin
        hit = 1'b1;
        wr_ok = 1'b1;
        rdata = 32'h00000000;
        if (paddr == `ECSF_OFF_APP1) begin
            rdata = {16'h0000, app_select_1_ff};
            wr_ok = (pwdata[31:16] == 16'h0000);
        end else if (paddr == `ECSF_OFF_APP2) begin
            rdata = {16'h0000, app_select_2_ff};
            wr_ok = (pwdata[31:16] == 16'h0000);
        end else if (paddr == `ECSF_OFF_APP3) begin
            rdata = {16'h0000, app_select_3_ff};
            wr_ok = (pwdata[31:16] == 16'h0000);
        end else if (paddr == `ECSF_OFF_APP4) begin
            rdata = {16'h0000, app_select_4_ff};
            wr_ok = (pwdata[31:16] == 16'h0000);
        end else if (paddr == `ECSF_OFF_LOSS) begin
            rdata = {18'h00000, loss_check_interval_ff};
            wr_ok = (pwdata[31:14] == 18'h00000) &&
                    (pwdata[13:0] <= `ECSF_OFF_CODE);
        end else if (paddr == `ECSF_OFF_CADDR) begin
            rdata = cmd_src_addr_ff;
        end else if (paddr == `ECSF_OFF_C3LIM) begin
            rdata = {18'h00000, cmd_src_octet3_limit_ff};
            wr_ok = (pwdata[31:8] == 24'h000000) ||
                    (pwdata == {18'h00000, `ECSF_OFF_CODE});
        end else if (paddr == `ECSF_OFF_C4LIM) begin
            rdata = {18'h00000, cmd_src_octet4_limit_ff};
            wr_ok = (pwdata[31:8] == 24'h000000) ||
                    (pwdata == {18'h00000, `ECSF_OFF_CODE});
        end else if (paddr == `ECSF_OFF_FADDR) begin
            rdata = filter_addr_ff; // RQ16
        end else if (paddr == `ECSF_OFF_F2LIM) begin
            rdata = {18'h00000, filter_octet2_limit_ff};
            wr_ok = (pwdata[31:8] == 24'h000000) ||
                    (pwdata == {18'h00000, `ECSF_OFF_CODE}); // RQ17
        end else if (paddr == `ECSF_OFF_F3LIM) begin
            rdata = {18'h00000, filter_octet3_limit_ff};
            wr_ok = (pwdata[31:8] == 24'h000000) ||
                    (pwdata == {18'h00000, `ECSF_OFF_CODE}); // RQ17
        end else if (paddr == `ECSF_OFF_F4LIM) begin
            rdata = {18'h00000, filter_octet4_limit_ff};
            wr_ok = (pwdata[31:8] == 24'h000000) ||
                    (pwdata == {18'h00000, `ECSF_OFF_CODE}); // RQ17
        end else if (paddr == `ECSF_OFF_LINK) begin
            rdata = {29'h00000000, link_speed_duplex_sel_ff};
            wr_ok = (pwdata[31:3] == 29'h00000000) &&
                    (pwdata[2:0] <= `ECSF_LINK_MAX); // RQ14
        end else if (paddr == `ECSF_OFF_IDUP) begin
            rdata = {22'h000000, dev_id_upper_ff};
            wr_ok = (pwdata[31:10] == 22'h000000) &&
                    (pwdata[9:0] <= `ECSF_IDUP_MAX) &&
                    !((pwdata[9:0] == `ECSF_IDUP_MAX) &&
                      (dev_id_lower_ff > `ECSF_IDLO_TOP)); // RQ13
        end else if (paddr == `ECSF_OFF_IDLO) begin
            rdata = {18'h00000, dev_id_lower_ff};
            wr_ok = (pwdata[31:14] == 18'h00000) &&
                    (pwdata[13:0] <= `ECSF_IDLO_MAX) &&
                    !((dev_id_upper_ff == `ECSF_IDUP_MAX) &&
                      (pwdata[13:0] > `ECSF_IDLO_TOP)); // RQ13
        end else if (paddr == `ECSF_OFF_CTRL) begin
            rdata = 32'h00000000;
        end else if (paddr == `ECSF_OFF_STAT) begin
            rdata = {27'h0000000, (act_faddr_ff != 32'h00000000),
                     (act_caddr_ff != 32'h00000000), bac_en_ff,
                     sup_ff, fault_ff};
            wr_ok = 1'b0;
        end else if (paddr == `ECSF_OFF_LCNT) begin
            rdata = {18'h00000, loss_cnt_ff};
            wr_ok = 1'b0;
        end else begin
            hit = 1'b0;
            wr_ok = 1'b0;
        end
    end

    // apb answer: one wait state, outputs registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (resp) begin
            pready <= 1'b1;
            pslverr <= ~hit | (pwrite & ~wr_ok);
            prdata <= pwrite ? 32'h00000000 : rdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // stored settings: rejected writes leave the old value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            app_select_1_ff <= `ECSF_RST_APP1;
            app_select_2_ff <= `ECSF_RST_APP2;
            app_select_3_ff <= `ECSF_RST_APP3;
            app_select_4_ff <= `ECSF_RST_APP4;
            loss_check_interval_ff <= `ECSF_RST_LOSS;
            cmd_src_addr_ff <= `ECSF_RST_ADDR;
            cmd_src_octet3_limit_ff <= `ECSF_RST_LIM;
            cmd_src_octet4_limit_ff <= `ECSF_RST_LIM;
            filter_addr_ff <= `ECSF_RST_ADDR;
            filter_octet2_limit_ff <= `ECSF_RST_LIM;
            filter_octet3_limit_ff <= `ECSF_RST_LIM;
            filter_octet4_limit_ff <= `ECSF_RST_LIM;
            link_speed_duplex_sel_ff <= `ECSF_RST_LINK;
            dev_id_upper_ff <= `ECSF_RST_IDUP;
            dev_id_lower_ff <= `ECSF_RST_IDLO;
        end else if (wr_fire) begin
            if (paddr == `ECSF_OFF_APP1) begin
                app_select_1_ff <= pwdata[15:0];
            end else if (paddr == `ECSF_OFF_APP2) begin
                app_select_2_ff <= pwdata[15:0];
            end else if (paddr == `ECSF_OFF_APP3) begin
                app_select_3_ff <= pwdata[15:0];
            end else if (paddr == `ECSF_OFF_APP4) begin
                app_select_4_ff <= pwdata[15:0];
            end else if (paddr == `ECSF_OFF_LOSS) begin
                loss_check_interval_ff <= pwdata[13:0];
            end else if (paddr == `ECSF_OFF_CADDR) begin
                cmd_src_addr_ff <= pwdata;
            end else if (paddr == `ECSF_OFF_C3LIM) begin
                cmd_src_octet3_limit_ff <= pwdata[13:0];
            end else if (paddr == `ECSF_OFF_C4LIM) begin
                cmd_src_octet4_limit_ff <= pwdata[13:0];
            end else if (paddr == `ECSF_OFF_FADDR) begin
                filter_addr_ff <= pwdata;
            end else if (paddr == `ECSF_OFF_F2LIM) begin
                filter_octet2_limit_ff <= pwdata[13:0];
            end else if (paddr == `ECSF_OFF_F3LIM) begin
                filter_octet3_limit_ff <= pwdata[13:0];
            end else if (paddr == `ECSF_OFF_F4LIM) begin
                filter_octet4_limit_ff <= pwdata[13:0];
            end else if (paddr == `ECSF_OFF_LINK) begin
                link_speed_duplex_sel_ff <= pwdata[2:0];
            end else if (paddr == `ECSF_OFF_IDUP) begin
                dev_id_upper_ff <= pwdata[9:0];
            end else if (paddr == `ECSF_OFF_IDLO) begin
                dev_id_lower_ff <= pwdata[13:0];
            end
        end
    end

    // the apply write copies settings in; a write to a stored
    // register in the same cycle is not yet seen
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_caddr_ff <= `ECSF_RST_ADDR;
            act_c3lim_ff <= `ECSF_RST_LIM;
            act_c4lim_ff <= `ECSF_RST_LIM;
            act_faddr_ff <= `ECSF_RST_ADDR;
            act_f2lim_ff <= `ECSF_RST_LIM;
            act_f3lim_ff <= `ECSF_RST_LIM;
            act_f4lim_ff <= `ECSF_RST_LIM;
            bac_en_ff <= 1'b0;
            autoneg_ff <= 1'b1;
            speed100_ff <= 1'b0;
            full_ff <= 1'b0;
        end else if (apply) begin // RQ19
            act_caddr_ff <= cmd_src_addr_ff;
            act_c3lim_ff <= cmd_src_octet3_limit_ff;
            act_c4lim_ff <= cmd_src_octet4_limit_ff;
            act_faddr_ff <= filter_addr_ff;
            act_f2lim_ff <= filter_octet2_limit_ff;
            act_f3lim_ff <= filter_octet3_limit_ff;
            act_f4lim_ff <= filter_octet4_limit_ff;
            bac_en_ff <= (app_select_1_ff == `ECSF_BAC_PORT) |
                         (app_select_2_ff == `ECSF_BAC_PORT) |
                         (app_select_3_ff == `ECSF_BAC_PORT) |
                         (app_select_4_ff == `ECSF_BAC_PORT); // RQ1
            autoneg_ff <= (link_speed_duplex_sel_ff == 3'h0); // RQ15
            speed100_ff <= (link_speed_duplex_sel_ff == 3'h1) |
                           (link_speed_duplex_sel_ff == 3'h2); // RQ15
            full_ff <= (link_speed_duplex_sel_ff == 3'h1) |
                       (link_speed_duplex_sel_ff == 3'h3); // RQ15
        end
    end

    // sender address checks
    wire c3_hit, c4_hit, f2_hit, f3_hit, f4_hit;
    wire c_def, c_in, f_ok;
    ecsf_octet_match u_c3 (.base(act_caddr_ff[15:8]), .limit(act_c3lim_ff),
        .val(rx_src_ip[15:8]), .hit(c3_hit));
    ecsf_octet_match u_c4 (.base(act_caddr_ff[7:0]), .limit(act_c4lim_ff),
        .val(rx_src_ip[7:0]), .hit(c4_hit));
    ecsf_octet_match u_f2 (.base(act_faddr_ff[23:16]), .limit(act_f2lim_ff),
        .val(rx_src_ip[23:16]), .hit(f2_hit));
    ecsf_octet_match u_f3 (.base(act_faddr_ff[15:8]), .limit(act_f3lim_ff),
        .val(rx_src_ip[15:8]), .hit(f3_hit));
    ecsf_octet_match u_f4 (.base(act_faddr_ff[7:0]), .limit(act_f4lim_ff),
        .val(rx_src_ip[7:0]), .hit(f4_hit));

    assign c_def = (act_caddr_ff != 32'h00000000); // RQ2
    assign c_in = c_def & (rx_src_ip[31:16] == act_caddr_ff[31:16]) &
                  c3_hit & c4_hit; // RQ5
    assign f_ok = (act_faddr_ff == 32'h00000000) |
                  ((rx_src_ip[31:24] == act_faddr_ff[31:24]) &
                   f2_hit & f3_hit & f4_hit); // RQ16

    // verdict one cycle after the frame strobe
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= 1'b0;
            pass_ff <= 1'b0;
            cmd_ff <= 1'b0;
        end else begin
            done_ff <= rx_valid;
            pass_ff <= rx_valid & f_ok;
            cmd_ff <= rx_valid & f_ok & rx_is_cmd & c_in; // RQ2 RQ20
        end
    end

    // signal-loss supervision
    wire net_ether, sup_off, heard, tick;
    assign net_ether = net_mode & cmd_src_ether;
    assign sup_off = (loss_check_interval_ff == `ECSF_OFF_CODE); // RQ7
    assign heard = rx_valid & f_ok & c_in; // RQ6
    assign tick = (tick_ff == TICK_CYCLES - 1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_ff <= 1'b0;
            tick_ff <= 32'h00000000;
            loss_cnt_ff <= 14'h0000;
        end else if (!net_ether || sup_off || apply ||
                     loss_check_interval_ff == 14'h0000) begin
            sup_ff <= 1'b0;
            tick_ff <= 32'h00000000;
            loss_cnt_ff <= 14'h0000;
        end else if (heard) begin
            sup_ff <= 1'b1; // RQ11
            tick_ff <= 32'h00000000; // RQ10
            loss_cnt_ff <= 14'h0000; // RQ10
        end else if (sup_ff) begin
            // count in 100 ms units to keep the counter narrow
            tick_ff <= tick ? 32'h00000000 : tick_ff + 32'h00000001;
            // a shrunk interval must not let the count run past it
            if (tick && loss_cnt_ff < loss_check_interval_ff) begin
                loss_cnt_ff <= loss_cnt_ff + 14'h0001;
            end
        end
    end

    // fault is held until the next apply; a new trip beats the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_ff <= 1'b0;
        end else if (net_mode && loss_check_interval_ff == 14'h0000) begin
            fault_ff <= 1'b1; // RQ8
        end else if (sup_ff && !sup_off &&
                     loss_cnt_ff >= loss_check_interval_ff) begin
            fault_ff <= 1'b1; // RQ6
        end else if (apply) begin
            fault_ff <= 1'b0;
        end
    end

    assign rx_done = done_ff;
    assign rx_pass = pass_ff;
    assign cmd_pass = cmd_ff;
    assign link_comm_fault = fault_ff;
    assign output_shutoff = fault_ff;
    assign bac_ip_en = bac_en_ff;
    assign link_autoneg = autoneg_ff;
    assign link_100m = speed100_ff;
    assign link_full_duplex = full_ff;
endmodule

// ---- rtl/ecsf_map.vh ----
// Functional notes
// RQ1 - value 47808 in any app slot enables BACnet
// RQ2 - all-zero command source rejects every command
// RQ3 - octets three, four: inclusive range, either order
// RQ4 - limit 9999 means single base value only
// RQ5 - octets one, two must match exactly
// RQ6 - loss from all in-range senders trips fault
// RQ7 - interval 9999 disables loss supervision
// RQ8 - interval zero faults on entering network mode
// RQ9 - senders transmit within the check interval
// RQ10 - any reception from master clears check counter
// RQ11 - supervision starts at first network-mode reception
// RQ12 - range must exclude other drives' addresses
// RQ13 - device id limited to 4194302 combined
// RQ14 - link selection accepts only 0 to 4
// RQ15 - link 0 auto, 1-2 100M, 3-4 10M
// RQ16 - filter octets 0-255, all zero disables
// RQ17 - filter limits octets 2-4, 9999 disables
// RQ18 - filter ranges inclusive in either order
// RQ19 - filter, link, command source apply after reset; the code loads them only on the CTRL apply write, and reset restores defaults
// RQ20 - outsiders lose commands, keep filtered traffic
`ifndef ECSF_MAP_VH
`define ECSF_MAP_VH

// register byte offsets
`define ECSF_OFF_APP1 8'h00
`define ECSF_OFF_APP2 8'h04
`define ECSF_OFF_APP3 8'h08
`define ECSF_OFF_APP4 8'h0c
`define ECSF_OFF_LOSS 8'h10
`define ECSF_OFF_CADDR 8'h14
`define ECSF_OFF_C3LIM 8'h18
`define ECSF_OFF_C4LIM 8'h1c
`define ECSF_OFF_FADDR 8'h20
`define ECSF_OFF_F2LIM 8'h24
`define ECSF_OFF_F3LIM 8'h28
`define ECSF_OFF_F4LIM 8'h2c
`define ECSF_OFF_LINK 8'h30
`define ECSF_OFF_IDUP 8'h34
`define ECSF_OFF_IDLO 8'h38
`define ECSF_OFF_CTRL 8'h3c
`define ECSF_OFF_STAT 8'h40
`define ECSF_OFF_LCNT 8'h44

// field positions
`define ECSF_CTRL_APPLY 0
`define ECSF_STAT_FAULT 0
`define ECSF_STAT_SUP 1
`define ECSF_STAT_BAC 2
`define ECSF_STAT_CDEF 3
`define ECSF_STAT_FEN 4

// reset values
`define ECSF_RST_APP1 16'h1389
`define ECSF_RST_APP2 16'hb0b5
`define ECSF_RST_APP3 16'hb0b6
`define ECSF_RST_APP4 16'h270f
`define ECSF_RST_LOSS 14'h0000
`define ECSF_RST_LIM 14'h270f
`define ECSF_RST_ADDR 32'h00000000
`define ECSF_RST_LINK 3'h0
`define ECSF_RST_IDUP 10'h000
`define ECSF_RST_IDLO 14'h0000

// codes and limits
`define ECSF_BAC_PORT 16'hbac0
`define ECSF_OFF_CODE 14'h270f
`define ECSF_LINK_MAX 3'h4
`define ECSF_IDUP_MAX 10'h1a3
`define ECSF_IDLO_MAX 14'h270f
`define ECSF_IDLO_TOP 14'h10ce

// timing: one interval unit is 100 ms
`define ECSF_TICK_MS 100
`define ECSF_CLK_MHZ 50

`endif

// ---- rtl/ecsf_octet_match.v ----
`timescale 1ns/1ns
`include "ecsf_map.vh"
module ecsf_octet_match (
    // settings
    input wire [7:0] base,
    input wire [13:0] limit,
    // sender octet
    input wire [7:0] val,
    // verdict
    output wire hit
);
    wire lim_off;
    wire [7:0] lim8;
    wire [7:0] lo;
    wire [7:0] hi;

    assign lim_off = (limit == `ECSF_OFF_CODE); // RQ4 RQ17
    assign lim8 = limit[7:0];
    // order of base and limit is free
    assign lo = (base < lim8) ? base : lim8; // RQ3 RQ18
    assign hi = (base < lim8) ? lim8 : base; // RQ3 RQ18
    assign hit = lim_off ? (val == base) : ((val >= lo) && (val <= hi));
endmodule

// ---- dv/ecsf_chk.sv ----
`timescale 1ns/1ns
module ecsf_chk (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    // frames
    input wire rx_valid,
    input wire rx_is_cmd,
    input wire rx_done,
    input wire rx_pass,
    input wire cmd_pass,
    // status
    input wire link_comm_fault,
    input wire output_shutoff,
    input wire link_autoneg,
    input wire link_100m,
    input wire link_full_duplex
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_rx_ans;
        rx_valid |=> rx_done;
    endproperty
    a_rx_ans: assert property (p_rx_ans) else $error("rx lost");
    property p_rx_src;
        rx_done |-> $past(rx_valid);
    endproperty
    a_rx_src: assert property (p_rx_src) else $error("rx spur");
    property p_pass_sub;
        (rx_pass |-> rx_done) and (cmd_pass |-> rx_pass);
    endproperty
    a_pass_sub: assert property (p_pass_sub) else $error("pass");
    property p_cmd_kind;
        cmd_pass |-> $past(rx_is_cmd);
    endproperty
    a_cmd_kind: assert property (p_cmd_kind) else $error("cmd");
    property p_shut;
        link_comm_fault == output_shutoff;
    endproperty
    a_shut: assert property (p_shut) else $error("shutoff");
    // fault leaves only through a completed write
    property p_clr;
        $fell(link_comm_fault) |-> $past(psel && pwrite && pready);
    endproperty
    a_clr: assert property (p_clr) else $error("fault dropped");
    property p_link;
        link_autoneg |-> !link_100m && !link_full_duplex;
    endproperty
    a_link: assert property (p_link) else $error("link");
    property p_rdy;
        $rose(psel && penable) |=> pready ##1 !pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("pslverr");
    c_cmd: cover property (cmd_pass);
    c_trip: cover property ($rose(link_comm_fault));
    c_err: cover property (pslverr);
endmodule

bind ecsf_top ecsf_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_is_cmd(rx_is_cmd),
    .rx_done(rx_done), .rx_pass(rx_pass), .cmd_pass(cmd_pass),
    .link_comm_fault(link_comm_fault), .output_shutoff(output_shutoff),
    .link_autoneg(link_autoneg), .link_100m(link_100m),
    .link_full_duplex(link_full_duplex));

// ---- dv/ecsf_master_model.sv ----
`timescale 1ns/1ns
module ecsf_master_model (
    // clock
    input wire pclk,
    // frame towards the block
    output logic rx_valid,
    output logic [31:0] rx_src_ip,
    output logic rx_is_cmd
);
    initial begin
        rx_valid = 1'b0;
        rx_src_ip = 32'h0;
        rx_is_cmd = 1'b0;
    end
    // one frame per call; pacing is the caller's job
    task send(input logic [31:0] ip, input logic cmd);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_src_ip <= ip;
        rx_is_cmd <= cmd;
        @(posedge pclk);
        rx_valid <= 1'b0;
        // idle lines invert so a stale sender never looks valid
        rx_src_ip <= ~ip;
        rx_is_cmd <= ~cmd;
    endtask
endmodule

// ---- dv/test_ethernet_command_source_filter.sv ----
`timescale 1ns/1ns
`include "ecsf_map.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    error_cnt++; $display("ERROR t=%0t got %h exp %h", $time, a, b); \
    end end
module test_ethernet_command_source_filter;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat, cb = 0, fb = 0, ip;
    logic pready, pslverr, rerr, net_mode = 0, cmd_src_ether = 0;
    logic rx_valid, rx_is_cmd, rx_done, rx_pass, cmd_pass;
    logic [31:0] rx_src_ip;
    logic link_comm_fault, output_shutoff, bac_ip_en;
    logic link_autoneg, link_100m, link_full_duplex;
    logic [13:0] c3l = `ECSF_OFF_CODE, c4l = `ECSF_OFF_CODE;
    logic [13:0] f2l = `ECSF_OFF_CODE, f3l = `ECSF_OFF_CODE;
    logic [13:0] f4l = `ECSF_OFF_CODE;
    logic [31:0] corner [4] = '{32'hc0a83269, 32'hc0a83264,
        32'hc0a83369, 32'hc0a93269};
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    always #10 pclk = ~pclk;
    // small tick keeps the loss interval short
    ecsf_top #(.TICK_CYCLES(10)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .net_mode(net_mode),
        .cmd_src_ether(cmd_src_ether), .rx_valid(rx_valid),
        .rx_src_ip(rx_src_ip), .rx_is_cmd(rx_is_cmd), .rx_done(rx_done),
        .rx_pass(rx_pass), .cmd_pass(cmd_pass),
        .link_comm_fault(link_comm_fault),
        .output_shutoff(output_shutoff), .bac_ip_en(bac_ip_en),
        .link_autoneg(link_autoneg), .link_100m(link_100m),
        .link_full_duplex(link_full_duplex));
    ecsf_master_model u_master (.pclk(pclk), .rx_valid(rx_valid),
        .rx_src_ip(rx_src_ip), .rx_is_cmd(rx_is_cmd));
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task finish_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // no cycle count assumed; the bench timeout ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        // outputs launched by this edge settle before any check
        #1;
    endtask
    task apply;
        apb(1, `ECSF_OFF_CTRL, 32'h1);
    endtask
    function logic inr(logic [7:0] v, b, logic [13:0] l);
        if (l == `ECSF_OFF_CODE)
            return v == b;
        return (v >= b || v >= l) && (v <= b || v <= l);
    endfunction
    function logic fexp(logic [31:0] i);
        return fb == 0 || (i[31:24] == fb[31:24]
            && inr(i[23:16], fb[23:16], f2l)
            && inr(i[15:8], fb[15:8], f3l) && inr(i[7:0], fb[7:0], f4l));
    endfunction
    function logic cexp(logic [31:0] i);
        return cb != 0 && i[31:16] == cb[31:16]
            && inr(i[15:8], cb[15:8], c3l) && inr(i[7:0], cb[7:0], c4l);
    endfunction
    task frame(input logic [31:0] i, input logic c);
        u_master.send(i, c);
        #1;
        `CHK(rx_done, 1'b1)
        `CHK(rx_pass, fexp(i))
        `CHK(cmd_pass, fexp(i) && cexp(i) && c)
    endtask
    initial begin
        void'($urandom(78742));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, `ECSF_OFF_APP1, 0);
        `CHK(rdat, 32'(`ECSF_RST_APP1))
        apb(0, `ECSF_OFF_C4LIM, 0);
        `CHK(rdat, 32'(`ECSF_RST_LIM))
        `CHK(bac_ip_en, 1'b0)
        apb(1, `ECSF_OFF_APP3, 32'(`ECSF_BAC_PORT));
        `CHK(bac_ip_en, 1'b0)
        apply();
        `CHK(bac_ip_en, 1'b1)
        $display("app select done");
        for (int s = 0; s < 5; s++) begin
            apb(1, `ECSF_OFF_LINK, s);
            apply();
            `CHK({link_autoneg, link_100m, link_full_duplex}, {s == 0,
                s == 1 || s == 2, s == 1 || s == 3})
        end
        apb(1, `ECSF_OFF_LINK, 32'h5);
        `CHK(rerr, 1'b1)
        apb(1, `ECSF_OFF_IDUP, 32'h1a3);
        apb(1, `ECSF_OFF_IDLO, 32'h10cf);
        `CHK(rerr, 1'b1)
        apb(1, `ECSF_OFF_IDLO, 32'h10ce);
        `CHK(rerr, 1'b0)
        apb(1, 8'h48, 0);
        `CHK(rerr, 1'b1)
        $display("settings done");
        frame(corner[0], 1);
        // cmd range keeps other drives out; octet4 limit below base
        apb(1, `ECSF_OFF_CADDR, 32'hc0a8326e);
        apb(1, `ECSF_OFF_C4LIM, 32'h64);
        apb(1, `ECSF_OFF_FADDR, 32'hc0aa2869);
        apb(1, `ECSF_OFF_F2LIM, 32'ha0);
        apb(1, `ECSF_OFF_F3LIM, 32'h3c);
        frame(corner[0], 1);
        apply();
        cb = 32'hc0a8326e;
        c4l = 14'h64;
        fb = 32'hc0aa2869;
        f2l = 14'ha0;
        f3l = 14'h3c;
        for (int k = 0; k < 80; k++) begin
            ip = {$urandom % 2 ? 8'hc0 : 8'h0a, 8'(160 + $urandom % 11),
                8'(48 + $urandom % 5), 8'(98 + $urandom % 15)};
            frame(k < 4 ? corner[k] : ip, k < 4 ? 1'b1 : 1'($urandom));
        end
        $display("address filter done");
        apb(1, `ECSF_OFF_LOSS, 32'h2);
        @(posedge pclk);
        net_mode <= 1;
        cmd_src_ether <= 1;
        repeat (40) @(posedge pclk);
        `CHK(link_comm_fault, 1'b0)
        for (int k = 0; k < 5; k++) begin
            frame(corner[0], 0);
            repeat (12) @(posedge pclk);
            `CHK(link_comm_fault, 1'b0)
        end
        repeat (18) @(posedge pclk);
        `CHK(output_shutoff, 1'b1)
        apb(1, `ECSF_OFF_LOSS, 32'h270f);
        apply();
        frame(corner[0], 0);
        repeat (60) @(posedge pclk);
        `CHK(link_comm_fault, 1'b0)
        net_mode <= 0;
        apb(1, `ECSF_OFF_LOSS, 0);
        apb(0, `ECSF_OFF_APP1, 0);
        `CHK(rerr, 1'b0)
        `CHK(link_comm_fault, 1'b0)
        @(posedge pclk);
        net_mode <= 1;
        repeat (2) @(posedge pclk);
        #1;
        `CHK(link_comm_fault, 1'b1)
        $display("supervision done");
        finish_test();
    end
endmodule
